// file: irq_ctrl_pkg.sv
/*
  Constants for the six-source prioritised interrupt controller: latch
  positions, entry addresses, enable-bit positions, reset values, the
  acknowledge length and the sequencer state codes.
  Assumes a single instruction-cycle clock shared with the CPU sequencer.
*/
package irq_ctrl_pkg;
  // Number of request sources and latch positions
  localparam int         NUM_SRC      = 6;
  localparam int         LAT_EXT_HIGH = 5;
  localparam int         LAT_SERIAL   = 4;
  localparam int         LAT_TC_ONE   = 3;
  localparam int         LAT_TC_TWO   = 2;
  localparam int         LAT_TICK     = 1;
  localparam int         LAT_EXT_LOW  = 0;
  // Source enable register layout
  localparam int         ENA_WIDTH      = 4;
  localparam int         ENA_BIT_SERIAL = 3;
  localparam int         ENA_BIT_TC_ONE = 2;
  localparam int         ENA_BIT_SHARED = 1;
  localparam int         ENA_BIT_EXTLOW = 0;
  // Program counter width and entry addresses
  localparam int         PC_WIDTH       = 14;
  localparam logic [13:0] ENTRY_EXT_HIGH = 14'h0002;
  localparam logic [13:0] ENTRY_SERIAL   = 14'h0004;
  localparam logic [13:0] ENTRY_TC_ONE   = 14'h0006;
  localparam logic [13:0] ENTRY_TC_TWO   = 14'h0008;
  localparam logic [13:0] ENTRY_TICK     = 14'h000A;
  localparam logic [13:0] ENTRY_EXT_LOW  = 14'h000C;
  // Reset values
  localparam logic [5:0] LATCH_RESET   = 6'h00;
  localparam logic [3:0] ENABLE_RESET  = 4'h0;
  localparam logic       MASTER_RESET  = 1'b0;
  localparam logic       PIN_IDLE      = 1'b1;
  // Acknowledge sequence length in instruction cycles
  localparam int         ACK_CYCLES    = 2;
  // Acknowledge sequencer states
  typedef enum logic [1:0] {
    ACK_IDLE   = 2'b00,
    ACK_FIRST  = 2'b01,
    ACK_SECOND = 2'b10
  } ack_state_t;
endpackage

// file: irq_ctrl.sv
/*
  Six-source prioritised interrupt controller for a 4-bit CPU core.
  Holds request latches, the master enable and the source enable register,
  picks the highest pending enabled request and runs a two-cycle
  acknowledge that hands an entry address to the sequencer.
  Assumes the CPU sequencer decodes instructions and drives the one-cycle
  strobes below, owns the stack and program counter, and that all inputs
  are synchronous to the instruction-cycle clock.
*/
// Summary of operation
// - Six sources, each latched, fixed priority order
// - Acceptance loads the source's fixed entry address
// - Highest priority enabled pending request wins
// - Latch sets on request, clears on acceptance
// - Mask zero bits clear latches, never set
// - Master enable gates all acceptance, resets low
// - Enable-clear sets, disable-clear clears master
// - Four-bit enable register masks all but high
// - Enable bit one gates both shared sources
// - Enable register swapped with accumulator only
// - Masked requests stay latched until cleared
// - Acknowledge takes two cycles after instruction
// - Acknowledge pushes, loads entry, clears master, latch
// - Return pops state and sets master enable
// - External latches set on pin falling edge
// - High external source ignores enable register
`timescale 1ns/10ps
module irq_ctrl (
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire logic                          ext_irq_high_pin_n,
  input  wire logic                          ext_irq_low_pin_n,
  input  wire logic                          serial_irq,
  input  wire logic                          tc_one_overflow_irq,
  input  wire logic                          tc_two_overflow_irq,
  input  wire logic                          interval_tick_irq,
  input  wire logic                          instr_end,
  input  wire logic                          timer_busy,
  input  wire logic                          latch_clear_and_enable,
  input  wire logic                          latch_clear_and_disable,
  input  wire logic                          latch_only_clear,
  input  wire logic [irq_ctrl_pkg::NUM_SRC-1:0] clear_mask,
  input  wire logic                          enable_exchange,
  input  wire logic [irq_ctrl_pkg::ENA_WIDTH-1:0] acc_in,
  input  wire logic                          return_from_irq,
  output logic [irq_ctrl_pkg::ENA_WIDTH-1:0] acc_out,
  output logic                               ack_busy,
  output logic                               push_state,
  output logic                               load_entry,
  output logic [irq_ctrl_pkg::PC_WIDTH-1:0]  entry_addr,
  output logic                               set_status_flag,
  output logic                               pop_state,
  output logic [irq_ctrl_pkg::NUM_SRC-1:0]   request_latch,
  output logic                               master_irq_enable,
  output logic [irq_ctrl_pkg::ENA_WIDTH-1:0] source_enable_reg
);
  import irq_ctrl_pkg::*;

  // Registered copies of the two external pins for edge detection
  logic                 high_pin_reg;
  logic                 low_pin_reg;
  // One-cycle set pulses per latch
  logic [NUM_SRC-1:0]   set_vec;
  // Per-source acceptance qualifier
  logic [NUM_SRC-1:0]   allowed;
  // Pending and accepted vectors
  logic [NUM_SRC-1:0]   eligible;
  logic [NUM_SRC-1:0]   grant_onehot;
  logic [NUM_SRC-1:0]   grant_reg;
  logic [NUM_SRC-1:0]   ack_clear;
  logic [NUM_SRC-1:0]   instr_clear;
  logic                 any_clear_instr;
  // Entry address looked up from the grant
  logic [PC_WIDTH-1:0]  entry_next;
  // Acknowledge sequencer
  ack_state_t           state_reg;
  ack_state_t           state_next;
  logic                 accept;

  // Pin history; pins idle high
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      high_pin_reg <= PIN_IDLE;
      low_pin_reg  <= PIN_IDLE;
    end else begin
      high_pin_reg <= ext_irq_high_pin_n;
      low_pin_reg  <= ext_irq_low_pin_n;
    end
  end

  // Request set pulses in latch order
  always_comb begin
    set_vec               = '0;
    set_vec[LAT_EXT_HIGH] = high_pin_reg & ~ext_irq_high_pin_n;
    set_vec[LAT_SERIAL]   = serial_irq;
    set_vec[LAT_TC_ONE]   = tc_one_overflow_irq;
    set_vec[LAT_TC_TWO]   = tc_two_overflow_irq;
    set_vec[LAT_TICK]     = interval_tick_irq;
    set_vec[LAT_EXT_LOW]  = low_pin_reg & ~ext_irq_low_pin_n;
  end

  // Per-source permit conditions from the enable register
  always_comb begin
    allowed               = '0;
    allowed[LAT_EXT_HIGH] = 1'b1;
    allowed[LAT_SERIAL]   = source_enable_reg[ENA_BIT_SERIAL];
    allowed[LAT_TC_ONE]   = source_enable_reg[ENA_BIT_TC_ONE];
    allowed[LAT_TC_TWO]   = source_enable_reg[ENA_BIT_SHARED];
    allowed[LAT_TICK]     = source_enable_reg[ENA_BIT_SHARED];
    allowed[LAT_EXT_LOW]  = source_enable_reg[ENA_BIT_EXTLOW];
  end

  // Eligible requests; master enable blocks all of them
  assign eligible = request_latch & allowed & {NUM_SRC{master_irq_enable}};

  // Fixed priority: highest latch index wins
  always_comb begin
    grant_onehot = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (eligible[i]) begin
        grant_onehot = '0;
        grant_onehot[i] = 1'b1;
      end
    end
  end

  // Acceptance at an instruction boundary with no timer work pending
  assign accept = (state_reg == ACK_IDLE) & instr_end & ~timer_busy
                  & (|eligible);

  // Acknowledge sequencer state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= ACK_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Two-cycle acknowledge: IDLE -> FIRST -> SECOND -> IDLE
  always_comb begin
    case (state_reg)
      ACK_IDLE:   state_next = accept ? ACK_FIRST : ACK_IDLE;
      ACK_FIRST:  state_next = ACK_SECOND;
      ACK_SECOND: state_next = ACK_IDLE;
      default:    state_next = ACK_IDLE;
    endcase
  end

  // Grant captured at acceptance, held through the acknowledge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      grant_reg <= '0;
    end else if (accept) begin
      grant_reg <= grant_onehot;
    end
  end

  // Entry address from the held grant
  always_comb begin
    entry_next = '0;
    if (grant_reg[LAT_EXT_HIGH])     entry_next = ENTRY_EXT_HIGH;
    else if (grant_reg[LAT_SERIAL])  entry_next = ENTRY_SERIAL;
    else if (grant_reg[LAT_TC_ONE])  entry_next = ENTRY_TC_ONE;
    else if (grant_reg[LAT_TC_TWO])  entry_next = ENTRY_TC_TWO;
    else if (grant_reg[LAT_TICK])    entry_next = ENTRY_TICK;
    else if (grant_reg[LAT_EXT_LOW]) entry_next = ENTRY_EXT_LOW;
  end

  // Entry address register, updated in the first acknowledge cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      entry_addr <= '0;
    end else if (state_reg == ACK_FIRST) begin
      entry_addr <= entry_next;
    end
  end

  // Sequencer strobes
  assign ack_busy        = (state_reg != ACK_IDLE);
  assign push_state      = (state_reg == ACK_FIRST);
  assign load_entry      = (state_reg == ACK_SECOND);
  assign set_status_flag = (state_reg == ACK_SECOND);
  assign pop_state       = return_from_irq;

  // Clear vectors from acceptance and from latch instructions
  assign ack_clear       = accept ? grant_onehot : '0;
  assign any_clear_instr = latch_clear_and_enable | latch_clear_and_disable
                           | latch_only_clear;
  assign instr_clear     = any_clear_instr ? ~clear_mask : '0;

  // Request latches; a new set wins over any clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      request_latch <= LATCH_RESET;
    end else begin
      request_latch <= (request_latch & ~ack_clear & ~instr_clear)
                       | set_vec;
    end
  end

  // Master enable flip-flop
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      master_irq_enable <= MASTER_RESET;
    end else if (accept) begin
      master_irq_enable <= 1'b0;
    end else if (latch_clear_and_enable | return_from_irq) begin
      master_irq_enable <= 1'b1;
    end else if (latch_clear_and_disable) begin
      master_irq_enable <= 1'b0;
    end
  end

  // Source enable register, exchanged with the accumulator only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      source_enable_reg <= ENABLE_RESET;
      acc_out           <= '0;
    end else if (enable_exchange) begin
      source_enable_reg <= acc_in;
      acc_out           <= source_enable_reg;
    end
  end

  // Checks
  ack_two_cycles_a: assert property (@(posedge clock) disable iff (rst)
    accept |=> push_state ##1 load_entry ##1 !ack_busy)
    else $error("acknowledge length wrong");
  master_cleared_a: assert property (@(posedge clock) disable iff (rst)
    accept |=> !master_irq_enable)
    else $error("master enable not cleared on accept");
  // With the master off no new acknowledge may start on the next edge
  no_accept_off_a: assert property (@(posedge clock) disable iff (rst)
    !master_irq_enable |=> !push_state)
    else $error("acknowledge started while master disabled");
  latch_cleared_a: assert property (@(posedge clock) disable iff (rst)
    accept |=> ((request_latch & $past(grant_onehot))
               == ($past(set_vec) & $past(grant_onehot))))
    else $error("accepted latch not cleared");
  high_priority_a: assert property (@(posedge clock) disable iff (rst)
    (accept && master_irq_enable && request_latch[LAT_EXT_HIGH])
    |-> ##2 entry_addr == ENTRY_EXT_HIGH)
    else $error("high source not first");
  set_wins_a: assert property (@(posedge clock) disable iff (rst)
    |set_vec |=> ((request_latch & $past(set_vec)) == $past(set_vec)))
    else $error("request lost");
  return_from_irq_enables_a: assert property (@(posedge clock) disable iff (rst)
    (return_from_irq && !accept) |=> master_irq_enable)
    else $error("return did not enable");
  disable_instr_a: assert property (@(posedge clock) disable iff (rst)
    (latch_clear_and_disable && !return_from_irq && !latch_clear_and_enable)
    |=> !master_irq_enable)
    else $error("disable instruction ignored");
  masked_hold_a: assert property (@(posedge clock) disable iff (rst)
    (request_latch[LAT_SERIAL] && !source_enable_reg[ENA_BIT_SERIAL]
     && !any_clear_instr) |=> request_latch[LAT_SERIAL])
    else $error("masked request dropped");
  // A tick entry needs the shared enable as it stood at acceptance
  shared_gate_a: assert property (@(posedge clock) disable iff (rst)
    (load_entry && entry_addr == ENTRY_TICK)
    |-> $past(source_enable_reg[ENA_BIT_SHARED], 2))
    else $error("tick accepted while gated");

  acc_cover_c:   cover property (@(posedge clock) disable iff (rst) accept);
  nest_cover_c:  cover property (@(posedge clock) disable iff (rst)
    return_from_irq ##1 accept);
  clash_cover_c: cover property (@(posedge clock) disable iff (rst)
    |(set_vec & instr_clear));
endmodule

// file: irq_cpu_model.sv
/*
  Behavioural model of the CPU sequencer next to the interrupt controller.
  It produces instruction ends and timer work, and returns from service.
  Assumes the bench clock and reset; outputs change on the falling edge.
*/
`timescale 1ns/10ps
module irq_cpu_model (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic slow,
  input  wire logic auto_ret,
  input  wire logic load_entry,
  output logic      instr_end,
  output logic      timer_busy,
  output logic      return_from_irq
);
  logic [1:0] cyc;      // Position inside a slow instruction
  logic [2:0] ret_cnt;  // Cycles left in the service routine

  // Slow mode ends an instruction every second cycle, and every other
  // end still has timer work pending, so acceptance must wait for it
  always @(negedge clock or posedge rst) begin
    if (rst) begin
      cyc        <= 2'h0;
      instr_end  <= 1'b0;
      timer_busy <= 1'b0;
    end else begin
      cyc        <= cyc + 2'h1;
      instr_end  <= slow ? cyc[0] : 1'b1;
      timer_busy <= slow & (cyc == 2'h1);
    end
  end

  // Entry holds a short branch to a brief routine ending in a return
  always @(negedge clock or posedge rst) begin
    if (rst) begin
      ret_cnt         <= 3'h0;
      return_from_irq <= 1'b0;
    end else begin
      return_from_irq <= (ret_cnt == 3'h1);
      if (ret_cnt != 3'h0) begin
        ret_cnt <= ret_cnt - 3'h1;
      end else if (load_entry && auto_ret) begin
        ret_cnt <= 3'h4;
      end
    end
  end
endmodule

// file: irq_ctrl_test.sv
/*
  Self-checking bench for the interrupt controller: sources, pins and
  instruction strobes in, latches, enables and entry addresses checked.
  Assumes irq_ctrl_pkg, irq_ctrl and the irq_cpu_model sequencer model.
*/
`timescale 1ns/10ps
module irq_ctrl_test;
  import irq_ctrl_pkg::*;
  logic        clock, rst, slow, auto_ret, instr_end, timer_busy;
  logic        ext_irq_high_pin_n, ext_irq_low_pin_n, serial_irq;
  logic        tc_one_overflow_irq, tc_two_overflow_irq, interval_tick_irq;
  logic        latch_clear_and_enable, latch_clear_and_disable;
  logic        latch_only_clear, enable_exchange, return_from_irq;
  logic        ack_busy, push_state, load_entry, set_status_flag;
  logic        pop_state, master_irq_enable;
  logic [5:0]  clear_mask, request_latch, m;
  logic [3:0]  acc_in, acc_out, source_enable_reg, ena_m, src_v, stb;
  logic [13:0] entry_addr;
  logic [13:0] expq[$];  // Entry addresses still expected, oldest first
  int          errors, comparisons, cycles;

  // Source pulses and instruction strobes as two small vectors
  assign {serial_irq, tc_one_overflow_irq, tc_two_overflow_irq,
          interval_tick_irq} = src_v;
  assign {latch_clear_and_enable, latch_clear_and_disable,
          latch_only_clear, enable_exchange} = stb;

  irq_ctrl i_dut (.clock, .rst, .ext_irq_high_pin_n, .ext_irq_low_pin_n,
    .serial_irq, .tc_one_overflow_irq, .tc_two_overflow_irq,
    .interval_tick_irq, .instr_end, .timer_busy, .latch_clear_and_enable,
    .latch_clear_and_disable, .latch_only_clear, .clear_mask,
    .enable_exchange, .acc_in, .return_from_irq, .acc_out, .ack_busy,
    .push_state, .load_entry, .entry_addr, .set_status_flag, .pop_state,
    .request_latch, .master_irq_enable, .source_enable_reg);
  irq_cpu_model i_cpu (.clock, .rst, .slow, .auto_ret, .load_entry,
    .instr_end, .timer_busy, .return_from_irq);

  always #12.5 clock = ~clock;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Falling edge on one pin, each level held two cycles
  task automatic pin_fall(input bit high);
    if (high)
      ext_irq_high_pin_n = 1'b0;
    else
      ext_irq_low_pin_n = 1'b0;
    repeat (2) @(negedge clock);
    ext_irq_high_pin_n = 1'b1;
    ext_irq_low_pin_n = 1'b1;
    repeat (2) @(negedge clock);
  endtask

  // One cycle of source pulses with one strobe, one-hot in k
  task automatic drive(input logic [3:0] s, input logic [3:0] k,
                       input logic [5:0] mk, input logic [3:0] a);
    @(negedge clock); // Idle cycle so a strobe never re-rises as it falls
    src_v = s;
    stb = k;
    clear_mask = mk;
    acc_in = a;
    @(negedge clock);
    src_v = 4'h0;
    stb = 4'h0;
  endtask

  // Swap the enable register, old value comes back
  task automatic xchg(input logic [3:0] v);
    drive(4'h0, 4'h1, clear_mask, v);
    check(source_enable_reg, v);
    check(acc_out, ena_m);
    ena_m = v;
  endtask

  task automatic raise_all;
    pin_fall(1'b1);
    pin_fall(1'b0);
    drive(4'hF, 4'h0, clear_mask, acc_in);
  endtask

  // Let the noted acceptances happen, bounded, then the return
  task automatic settle;
    for (int i = 0; i < 300 && expq.size() != 0; i++)
      @(negedge clock);
    repeat (8) @(negedge clock);
    check(16'(expq.size()), 16'h0000);
  endtask

  // Each entry seen is compared with the oldest one noted
  always @(posedge clock) begin
    check(pop_state, return_from_irq);
    if (load_entry === 1'b1) begin
      check({ack_busy, push_state}, 2'b10);
      check(set_status_flag, 1'b1);
      check(master_irq_enable, 1'b0);
      if (expq.size() == 0)
        check(entry_addr, 14'h3FFF);
      else
        check(entry_addr, expq.pop_front());
    end
  end

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      stop_test();
    end
  end

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    slow = 1'b0;
    auto_ret = 1'b1;
    ext_irq_high_pin_n = 1'b1;
    ext_irq_low_pin_n = 1'b1;
    src_v = 4'h0;
    stb = 4'h0;
    clear_mask = 6'h3F;
    acc_in = 4'h0;
    ena_m = 4'h0;
    errors = 0;
    comparisons = 0;
    cycles = 0;
    void'($urandom(67103));
    repeat (4) @(negedge clock);
    rst = 1'b0;
    check(request_latch, 6'h00);
    check(master_irq_enable, 1'b0);
    xchg(4'($urandom));
    xchg(4'hF);
    $display("test reset_exchange done");
    // All six pending, master off, then enabled
    raise_all();
    check(request_latch, 6'h3F);
    expq = '{14'h0002, 14'h0004, 14'h0006, 14'h0008, 14'h000A, 14'h000C};
    drive(4'h0, 4'h8, 6'h3F, acc_in);
    check(master_irq_enable, 1'b1);
    settle();
    check(request_latch, 6'h00);
    check(master_irq_enable, 1'b1);
    $display("test priority done");
    // Per-source enables with slow instructions and timer work
    slow = 1'b1;
    xchg(4'h0);
    drive(4'hB, 4'h0, clear_mask, acc_in);
    pin_fall(1'b0);
    check(request_latch, 6'h17);
    expq.push_back(14'h0002);
    pin_fall(1'b1);
    settle();
    check(request_latch, 6'h17);
    expq = '{14'h0008, 14'h000A};
    xchg(4'h2);
    settle();
    check(request_latch, 6'h11);
    drive(4'h0, 4'h2, 6'h2E, acc_in);
    check(request_latch, 6'h00);
    check(master_irq_enable, 1'b1);
    drive(4'h0, 4'h4, 6'h3F, acc_in);
    check(master_irq_enable, 1'b0);
    $display("test masking done");
    // Random clear masks, with a new request in the clearing cycle
    slow = 1'b0;
    for (int i = 0; i < 4; i++) begin
      m = 6'($urandom) & 6'h2F;
      raise_all();
      drive(4'h8, (i[0] ? 4'h2 : 4'h4), m, acc_in);
      check(request_latch, m | 6'h10);
    end
    $display("test clear_mask done");
    // Second reset with state held
    xchg(4'($urandom) | 4'h1);
    rst = 1'b1;
    @(negedge clock);
    check(request_latch, 6'h00);
    check(source_enable_reg, 4'h0);
    check(master_irq_enable, 1'b0);
    repeat (3) @(negedge clock);
    rst = 1'b0;
    ena_m = 4'h0;
    xchg(4'h5);
    $display("test reset_midrun done");
    stop_test();
  end
endmodule
